// ===== verilog/sfc_pkg.sv
/*
 * Shared constants and types of the serial flash command decoder:
 * opcodes, address geometry, status bit positions, timing and carriers.
 * Assumes one system clock of 100 MHz and an 18-bit byte array.
 */
// Operation
// - Locked top/bottom sector blocks program and erase
// - Reset clears both sector lock flags
// - Opcode, address, data move as 8-bit bytes
// - Frame starts at select fall, MSB-first rising
// - Select rising mid-byte abandons the command
// - Read 03 streams bytes with auto-increment
// - Read pointer wraps from top to zero
// - Fast read 0B adds one dummy byte
// - Opcode 02 programs one byte
// - Program into locked area silently ignored
// - Self-timed write starts after select rises
// - Erase opcodes 20, 52, D8 decoded
// - Erase range chosen from bits 12/15/16
// - AD writes even byte then odd byte
// - Status reads repeat value until deselect
// - Opcode 70 enables busy on serial output in auto-increment mode
// - Opcode 80 disables busy on serial output
// - Ident read returns maker or part code
// - Address bits above array width ignored
// - Busy bit high while writing
// - Program completion clears write enable latch, except in auto-increment mode
package sfc_pkg;
    // Array geometry
    localparam int ADDR_W = 18;
    localparam logic [17:0] ADDR_TOP = 18'h3_FFFF;
    localparam int SECTOR_SHIFT = 12;
    localparam int BLOCK32_SHIFT = 15;
    localparam int BLOCK64_SHIFT = 16;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] ERASED = 8'hFF;
    // Opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_BYTE_PROG = 8'h02;
    localparam logic [7:0] OP_AUTO_INC_PROG = 8'hAD;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS2_READ = 8'h35;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_IDENT_READ_A = 8'h90;
    localparam logic [7:0] OP_IDENT_READ_B = 8'hAB;
    localparam logic [7:0] OP_BUSY_OUT_EN = 8'h70;
    localparam logic [7:0] OP_BUSY_OUT_DIS = 8'h80;
    // Status bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_AAI_BIT = 6;
    localparam int ST2_TOP_BIT = 2;
    localparam int ST2_BOT_BIT = 3;
    // Identity codes, values arbitrary
    localparam logic [7:0] ID_MAKER = 8'h5A;
    localparam logic [7:0] ID_PART = 8'hA5;
    // Self-timed program settle time
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 1000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Link pins after synchronising
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sfc_link_s;
    // One array write
    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } sfc_wr_s;
    typedef enum logic [2:0] {CS_OPCODE, CS_ADDR, CS_DUMMY, CS_DATA_IN, CS_DATA_OUT, CS_IGNORE}
        sfc_cmd_state_e;
    typedef enum logic [1:0] {EN_IDLE, EN_WRITE, EN_WAIT} sfc_eng_state_e;
endpackage : sfc_pkg

// ===== verilog/sfc_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes the inputs are slow compared with the sampling clock.
 */
module sfc_sync import sfc_pkg::*; #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First stage, read only by the second
    logic [W-1:0] meta;

    // One two-stage chain per bit
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    meta[g] <= 1'b1;
                    q_o[g] <= 1'b1;
                end else begin
                    meta[g] <= d_i[g];
                    q_o[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule : sfc_sync

// ===== verilog/sfc_mem.sv
/*
 * Byte array of the flash, one write port and one registered read port.
 * Assumes the writer never writes and expects read-back in one cycle.
 */
module sfc_mem import sfc_pkg::*; #(
    parameter int AW = ADDR_W
) (
    // Clock
    input wire logic clk_sys_i,
    // Write
    input wire sfc_wr_s wr_i,
    // Read
    input wire logic [AW-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    // Storage, no reset: contents survive like the cells do
    logic [7:0] cells [2**AW];

    // Write port
    always_ff @(posedge clk_sys_i) begin
        if (wr_i.en) begin
            cells[wr_i.addr[AW-1:0]] <= wr_i.data;
        end
    end

    // Registered read
    always_ff @(posedge clk_sys_i) begin
        rd_data_o <= cells[rd_addr_i];
    end
endmodule : sfc_mem

// ===== verilog/sfc_core.sv
/*
 * Command decoder of a serial flash: samples the link pins, decodes
 * opcodes, streams reads, and runs self-timed program and erase.
 * Assumes the link clock is far slower than clk_sys_i (4x at least).
 */
module sfc_core import sfc_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = ID_MAKER,
    parameter logic [7:0] PART_CODE = ID_PART,
    parameter int PROG_WAIT = PROG_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Link pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    // Sector lock control
    input wire logic lock_load_i,
    input wire logic top_sector_lock_i,
    input wire logic bottom_sector_lock_i,
    // Status
    output logic top_sector_lock_o,
    output logic bottom_sector_lock_o,
    output logic busy_o,
    output logic write_enable_latch_o,
    output logic aai_mode_o
);
    sfc_link_s lnk; // Synchronised pins
    logic sck_d, cs_n_d; // Previous samples
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    logic [2:0] bit_cnt; // Bit within byte
    logic [7:0] in_sh; // Input shifter
    logic byte_done; // Eighth bit taken
    logic [7:0] in_byte; // Whole received byte
    sfc_cmd_state_e cst;
    logic [7:0] cmd; // Latched opcode
    logic [1:0] addr_cnt; // Address bytes seen
    logic [ADDR_W-1:0] addr; // Command address pointer
    logic [7:0] dbuf [2]; // Program data
    logic dcnt; // Data bytes seen
    logic cmd_ready; // All bytes present
    logic [7:0] out_sh; // Output shifter
    logic out_act; // Driving data
    logic [7:0] out_src; // Next byte to send
    logic [7:0] rd_data;
    logic tsl, bsl, write_enable_latch, auto_increment_program, rb_en; // Flags
    sfc_eng_state_e est;
    logic [ADDR_W-1:0] wr_ptr, wr_end, aai_addr;
    logic wr_erase, wr_idx;
    logic [$clog2(PROG_WAIT+1)-1:0] wait_cnt;
    logic eng_start, eng_done;
    sfc_wr_s wr;
    logic [ADDR_W-1:0] rng_base, rng_end;

    // Range bits cleared by an erase or auto-increment opcode
    function automatic logic [ADDR_W-1:0] range_mask(input logic [7:0] op);
        case (op)
            OP_SECTOR_ERASE: range_mask = ADDR_W'((1 << SECTOR_SHIFT) - 1);
            OP_BLOCK32_ERASE: range_mask = ADDR_W'((1 << BLOCK32_SHIFT) - 1);
            OP_BLOCK64_ERASE: range_mask = ADDR_W'((1 << BLOCK64_SHIFT) - 1);
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: range_mask = ADDR_TOP;
            OP_AUTO_INC_PROG: range_mask = ADDR_W'(1);
            default: range_mask = '0;
        endcase
    endfunction : range_mask

    // Range touches a locked end sector
    function automatic logic hits_lock(input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] e,
                                       input logic t, input logic bo);
        hits_lock = (t && (e >> SECTOR_SHIFT) == (ADDR_TOP >> SECTOR_SHIFT))
                 || (bo && (b >> SECTOR_SHIFT) == '0);
    endfunction : hits_lock

    // Whether the opcode needs write permission
    function automatic logic is_write(input logic [7:0] op);
        is_write = op inside {OP_BYTE_PROG, OP_AUTO_INC_PROG, OP_SECTOR_ERASE,
            OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    endfunction : is_write

    // Pin synchroniser
    sfc_sync #(.W(3)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i({cs_n_i, sck_i, si_i}),
        .q_o(lnk)
    );

    // Edge finders on the synchronised pins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sck_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sck_d <= lnk.sck;
            cs_n_d <= lnk.cs_n;
        end
    end
    assign sck_rise = lnk.sck && !sck_d && !lnk.cs_n;
    assign sck_fall = !lnk.sck && sck_d && !lnk.cs_n;
    assign cs_fall = !lnk.cs_n && cs_n_d;
    assign cs_rise = lnk.cs_n && !cs_n_d;

    // Bit shifter, MSB first on rising clock, restarted by select
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || cs_fall) begin
            bit_cnt <= '0;
            in_sh <= '0;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            in_sh <= {in_sh[6:0], lnk.si};
        end
    end
    assign byte_done = sck_rise && bit_cnt == BIT_LAST;
    assign in_byte = {in_sh[6:0], lnk.si};

    // Command sequencer, one step per received byte
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || cs_fall || lnk.cs_n) begin
            cst <= CS_OPCODE;
            cmd_ready <= 1'b0;
            addr_cnt <= '0;
            dcnt <= 1'b0;
        end else if (byte_done) begin
            case (cst)
                CS_OPCODE: begin
                    cmd <= in_byte;
                    if (auto_increment_program && !(in_byte inside {OP_AUTO_INC_PROG, OP_WRITE_DISABLE,
                                                 OP_STATUS_READ})) begin
                        cst <= CS_IGNORE;
                    end else if (in_byte inside {OP_READ, OP_FAST_READ, OP_SECTOR_ERASE,
                        OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_BYTE_PROG, OP_IDENT_READ_A,
                        OP_IDENT_READ_B}) begin
                        cst <= CS_ADDR;
                    end else if (in_byte == OP_AUTO_INC_PROG) begin
                        cst <= auto_increment_program ? CS_DATA_IN : CS_ADDR;
                    end else if (in_byte inside {OP_STATUS_READ, OP_STATUS2_READ}) begin
                        cst <= CS_DATA_OUT;
                    end else begin
                        cst <= CS_IGNORE;
                        cmd_ready <= in_byte inside {OP_WRITE_ENABLE, OP_WRITE_DISABLE,
                            OP_BUSY_OUT_EN, OP_BUSY_OUT_DIS, OP_CHIP_ERASE_A,
                            OP_CHIP_ERASE_B};
                    end
                end
                CS_ADDR: begin
                    addr <= {addr[ADDR_W-9:0], in_byte};
                    addr_cnt <= addr_cnt + 2'h1;
                    if (addr_cnt == ADDR_BYTES - 2'h1) begin
                        case (cmd)
                            OP_FAST_READ: cst <= CS_DUMMY;
                            OP_BYTE_PROG, OP_AUTO_INC_PROG: cst <= CS_DATA_IN;
                            OP_READ, OP_IDENT_READ_A, OP_IDENT_READ_B: cst <= CS_DATA_OUT;
                            default: begin
                                cst <= CS_IGNORE;
                                cmd_ready <= 1'b1;
                            end
                        endcase
                    end
                end
                CS_DUMMY: cst <= CS_DATA_OUT;
                CS_DATA_IN: begin
                    dbuf[dcnt] <= in_byte;
                    dcnt <= 1'b1;
                    if (cmd == OP_BYTE_PROG || dcnt) begin
                        cst <= CS_IGNORE;
                        cmd_ready <= 1'b1;
                    end
                end
                CS_DATA_OUT: begin
                    if (cmd inside {OP_READ, OP_FAST_READ}) begin
                        addr <= addr + ADDR_W'(1);
                    end
                end
                CS_IGNORE: cmd_ready <= 1'b0;
                default: cst <= CS_IGNORE;
            endcase
        end
    end

    // Byte offered to the output shifter
    always_comb begin
        case (cmd)
            OP_STATUS_READ: begin
                out_src = '0;
                out_src[ST_BUSY_BIT] = busy_o;
                out_src[ST_WEL_BIT] = write_enable_latch;
                out_src[ST_AAI_BIT] = auto_increment_program;
            end
            OP_STATUS2_READ: begin
                out_src = '0;
                out_src[ST2_TOP_BIT] = tsl;
                out_src[ST2_BOT_BIT] = bsl;
            end
            OP_IDENT_READ_A, OP_IDENT_READ_B: out_src = addr[0] ? PART_CODE : MAKER_CODE;
            default: out_src = rd_data;
        endcase
    end

    // Output shifter, changes on falling clock, reloads at byte start
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || lnk.cs_n) begin
            out_sh <= '0;
            out_act <= 1'b0;
        end else if (sck_fall && cst == CS_DATA_OUT) begin
            out_act <= 1'b1;
            out_sh <= (bit_cnt == '0) ? out_src : {out_sh[6:0], 1'b0};
        end
    end

    // Serial output pin, inverted busy (high when ready) shown in its place in auto-increment mode when enabled
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
        end else if (auto_increment_program && rb_en && !lnk.cs_n) begin
            so_o <= !busy_o;
            so_oe_n_o <= 1'b0;
        end else begin
            so_o <= out_sh[7];
            so_oe_n_o <= !(out_act && !lnk.cs_n);
        end
    end

    // Range of the pending write, lower bits treated as don't-care
    assign rng_base = (auto_increment_program && cmd == OP_AUTO_INC_PROG) ? aai_addr : addr & ~range_mask(cmd);
    assign rng_end = rng_base | range_mask(cmd);
    // Launch only on a clean deselect with every byte present
    assign eng_start = cs_rise && bit_cnt == '0 && cmd_ready && est == EN_IDLE && write_enable_latch
        && is_write(cmd) && !hits_lock(rng_base, rng_end, tsl, bsl);

    // Non-write commands executed at deselect
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            write_enable_latch <= 1'b0;
            rb_en <= 1'b0;
            auto_increment_program <= 1'b0;
        end else if (eng_done && !auto_increment_program) begin
            write_enable_latch <= 1'b0;
        end else if (eng_start && cmd == OP_AUTO_INC_PROG) begin
            auto_increment_program <= 1'b1;
        end else if (cs_rise && bit_cnt == '0 && cmd_ready && est == EN_IDLE) begin
            case (cmd)
                OP_WRITE_ENABLE: write_enable_latch <= 1'b1;
                OP_WRITE_DISABLE: begin
                    write_enable_latch <= 1'b0;
                    auto_increment_program <= 1'b0;
                end
                OP_BUSY_OUT_EN: rb_en <= 1'b1;
                OP_BUSY_OUT_DIS: rb_en <= 1'b0;
                default: rb_en <= rb_en;
            endcase
        end
    end

    // Sector lock flags, cleared at reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tsl <= 1'b0;
            bsl <= 1'b0;
        end else if (lock_load_i) begin
            tsl <= top_sector_lock_i;
            bsl <= bottom_sector_lock_i;
        end
    end

    // Self-timed write engine: fill range, then settle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            est <= EN_IDLE;
            wait_cnt <= '0;
            wr_idx <= 1'b0;
        end else begin
            case (est)
                EN_IDLE: begin
                    if (eng_start) begin
                        est <= EN_WRITE;
                        wr_ptr <= rng_base;
                        wr_end <= rng_end;
                        wr_erase <= !(cmd inside {OP_BYTE_PROG, OP_AUTO_INC_PROG});
                        wr_idx <= 1'b0;
                    end
                end
                EN_WRITE: begin
                    wr_ptr <= wr_ptr + ADDR_W'(1);
                    wr_idx <= 1'b1;
                    if (wr_ptr == wr_end) begin
                        est <= EN_WAIT;
                        wait_cnt <= $bits(wait_cnt)'(PROG_WAIT);
                    end
                end
                EN_WAIT: begin
                    wait_cnt <= wait_cnt - 1'b1;
                    if (wait_cnt == 1) begin
                        est <= EN_IDLE;
                    end
                end
                default: est <= EN_IDLE;
            endcase
        end
    end
    assign eng_done = est == EN_WAIT && wait_cnt == 1;
    assign wr.en = est == EN_WRITE;
    assign wr.addr = wr_ptr;
    assign wr.data = wr_erase ? ERASED : dbuf[wr_idx];
    assign busy_o = est != EN_IDLE;

    // Next word address of auto-increment mode
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aai_addr <= '0;
        end else if (est == EN_WRITE && wr_ptr == wr_end) begin
            aai_addr <= wr_end + ADDR_W'(1);
        end
    end

    // Array
    sfc_mem #(.AW(ADDR_W)) u_mem (
        .clk_sys_i(clk_sys_i),
        .wr_i(wr),
        .rd_addr_i(addr),
        .rd_data_o(rd_data)
    );

    assign top_sector_lock_o = tsl;
    assign bottom_sector_lock_o = bsl;
    assign write_enable_latch_o = write_enable_latch;
    assign aai_mode_o = auto_increment_program;

    // Checks
    sequence s_wrap;
        byte_done && cst == CS_DATA_OUT && cmd == OP_READ && addr == ADDR_TOP;
    endsequence
    sequence s_busy_cmd;
        cs_rise && bit_cnt == '0 && cmd_ready && est == EN_IDLE && cmd == OP_BUSY_OUT_EN;
    endsequence
    property p_lock_reset;
        @(posedge clk_sys_i) rst_i |=> !tsl && !bsl;
    endproperty
    a_lock_reset: assert property (p_lock_reset) else $error("locks set after reset");
    property p_no_locked;
        @(posedge clk_sys_i) disable iff (rst_i) eng_start && tsl |-> rng_end < (ADDR_TOP
            & ~ADDR_W'((1 << SECTOR_SHIFT) - 1));
    endproperty
    a_no_locked: assert property (p_no_locked) else $error("write into locked top");
    property p_start_on_deselect;
        @(posedge clk_sys_i) disable iff (rst_i) eng_start |-> $rose(lnk.cs_n) ##1 busy_o;
    endproperty
    a_start_on_deselect: assert property (p_start_on_deselect) else $error("bad start");
    property p_abort;
        @(posedge clk_sys_i) disable iff (rst_i) cs_rise && bit_cnt != '0 |=> $stable(rb_en)
            && (!busy_o || $past(busy_o)) && ($stable(write_enable_latch) || $past(busy_o));
    endproperty
    a_abort: assert property (p_abort) else $error("partial byte executed");
    property p_wrap;
        @(posedge clk_sys_i) disable iff (rst_i) s_wrap |=> addr == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("read pointer did not wrap");
    property p_busy_out;
        @(posedge clk_sys_i) disable iff (rst_i) s_busy_cmd |=> rb_en;
    endproperty
    a_busy_out: assert property (p_busy_out) else $error("busy output not enabled");
    property p_wel_clear;
        @(posedge clk_sys_i) disable iff (rst_i) eng_done && !auto_increment_program |=> !write_enable_latch ##1 !write_enable_latch;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");
    property p_busy_len;
        @(posedge clk_sys_i) disable iff (rst_i) $rose(est == EN_WAIT) |-> busy_o [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy dropped early");
    property p_frame_start;
        @(posedge clk_sys_i) disable iff (rst_i) cs_fall |=> cst == CS_OPCODE && bit_cnt == '0;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame not restarted");
endmodule : sfc_core

// ===== tb/sfc_host_model.sv
/*
 * Host side of the serial link: frames, shifts bytes, samples so_o.
 * Assumes clk_sys_i runs; the link clock idles low between frames.
 */
module sfc_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Link pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Half link period in clocks, near 130 ns per bit
    localparam int HALF = 6;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // Select after an idle gap so the sync flops see it high
    task automatic sel();
        repeat (HALF) @(posedge clk_sys_i);
        cs_n_o <= 1'b0;
        repeat (HALF) @(posedge clk_sys_i);
    endtask : sel
    // Shift n bits MSB first; read bit taken at the rising edge
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge clk_sys_i);
            si_o <= tx[i];
            repeat (HALF) @(posedge clk_sys_i);
            sck_o <= 1'b1;
            rx[i] = so_i;
            repeat (HALF) @(posedge clk_sys_i);
            sck_o <= 1'b0;
        end
    endtask : bits
    // Released data line toggles so a stale value is never seen
    task automatic desel();
        repeat (HALF) @(posedge clk_sys_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
    endtask : desel
endmodule : sfc_host_model

// ===== tb/sfc_core_tb_top.sv
/*
 * Self-checking bench of the command decoder, driven through the host model.
 * Assumes a 100 MHz clock and a shortened program wait.
 */
module sfc_core_tb_top import sfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, sck, si, so, so_oe_n, busy, write_enable_latch, auto_increment_program, top_o, bot_o;
    logic lock_load = 1'b0;
    logic top_lock = 1'b0;
    logic bot_lock = 1'b0;
    // Busy seen shortly after the last write frame
    logic seen;
    logic [7:0] x;
    int num_errors = 0;
    int checks = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    sfc_core #(.PROG_WAIT(16)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n),
        .sck_i(sck), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .lock_load_i(lock_load),
        .top_sector_lock_i(top_lock), .bottom_sector_lock_i(bot_lock),
        .top_sector_lock_o(top_o), .bottom_sector_lock_o(bot_o), .busy_o(busy),
        .write_enable_latch_o(write_enable_latch), .aai_mode_o(auto_increment_program));
    sfc_host_model host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .so_i(so));
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hdr(input logic [7:0] op, input logic [23:0] a);
        host.sel();
        host.bits(op, 8, x);
        for (int i = 2; i >= 0; i--) host.bits(a[i*8+:8], 8, x);
    endtask : hdr
    task automatic one(input logic [7:0] op);
        host.sel();
        host.bits(op, 8, x);
        host.desel();
    endtask : one
    // Bounded wait for the engine to go idle
    task automatic idle();
        repeat (6) @(posedge clk_sys_i);
        seen = busy;
        for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk_sys_i);
        chk({7'h0, busy}, 8'h00);
    endtask : idle
    task automatic wr(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                      input int nd);
        one(OP_WRITE_ENABLE);
        hdr(op, a);
        if (nd > 0) host.bits(d, nd, x);
        host.desel();
        idle();
    endtask : wr
    // Two streamed bytes after the header, dummy byte for fast read
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e0,
                      input logic [7:0] e1);
        hdr(op, a);
        if (op === OP_FAST_READ) host.bits(8'h00, 8, x);
        host.bits(8'h00, 8, x);
        chk(x, e0);
        host.bits(8'h00, 8, x);
        chk(x, e1);
        host.desel();
    endtask : rd
    task automatic stat(input logic [7:0] op, input logic [7:0] e);
        host.sel();
        host.bits(op, 8, x);
        repeat (2) begin
            host.bits(8'h00, 8, x);
            chk(x, e);
        end
        host.desel();
    endtask : stat
    task automatic lk(input logic t, input logic b);
        @(posedge clk_sys_i);
        lock_load <= 1'b1;
        top_lock <= t;
        bot_lock <= b;
        @(posedge clk_sys_i);
        lock_load <= 1'b0;
    endtask : lk
    // Enable, then start an auto-increment word with both data bytes
    task automatic aai2(input logic [23:0] a, input logic [7:0] d0, input logic [7:0] d1);
        one(OP_WRITE_ENABLE);
        hdr(OP_AUTO_INC_PROG, a);
        host.bits(d0, 8, x);
        host.bits(d1, 8, x);
        host.desel();
    endtask : aai2
    // Empty frame: output enable and pin level as seen while selected
    task automatic pin(input logic [7:0] e);
        host.sel();
        chk({6'h0, so_oe_n, so}, e);
        host.desel();
    endtask : pin
    // Watchdog well above the expected run
    initial begin
        repeat (95000) @(posedge clk_sys_i);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk({4'h0, top_o, bot_o, busy, write_enable_latch}, 8'h00);
        stat(OP_STATUS_READ, 8'h00);
        one(OP_WRITE_ENABLE);
        stat(OP_STATUS_READ, 8'h02);
        stat(OP_STATUS2_READ, 8'h00);
        wr(OP_SECTOR_ERASE, 24'h00_0ABC, 8'h00, 0);
        wr(OP_SECTOR_ERASE, 24'h03_F123, 8'h00, 0);
        chk({7'h0, write_enable_latch}, 8'h00);
        wr(OP_BYTE_PROG, 24'h00_0FFF, 8'h3C, 8);
        chk({7'h0, seen}, 8'h01);
        chk({6'h0, busy, write_enable_latch}, 8'h00);
        wr(OP_BYTE_PROG, 24'h00_0FFE, 8'h81, 8);
        rd(OP_READ, 24'hFC_0FFE, 8'h81, 8'h3C);
        wr(OP_BYTE_PROG, 24'h03_FFFF, 8'h11, 8);
        wr(OP_BYTE_PROG, 24'h00_0000, 8'h22, 8);
        rd(OP_FAST_READ, 24'h03_FFFF, 8'h11, 8'h22);
        rd(OP_READ, 24'h03_FFFF, 8'h11, 8'h22);
        $display("test program and read done");
        wr(OP_BYTE_PROG, 24'h00_0FF0, 8'h00, 5);
        rd(OP_READ, 24'h00_0FF0, 8'hFF, 8'hFF);
        lk(1'b1, 1'b0);
        stat(OP_STATUS2_READ, 8'h04);
        wr(OP_BYTE_PROG, 24'h03_FFFE, 8'h00, 8);
        chk({7'h0, seen}, 8'h00);
        wr(OP_BLOCK64_ERASE, 24'h03_0000, 8'h00, 0);
        wr(OP_BLOCK32_ERASE, 24'h03_8000, 8'h00, 0);
        one(OP_WRITE_ENABLE);
        one(OP_CHIP_ERASE_B);
        idle();
        chk({7'h0, seen}, 8'h00);
        rd(OP_READ, 24'h03_FFFE, 8'hFF, 8'h11);
        lk(1'b0, 1'b1);
        wr(OP_SECTOR_ERASE, 24'h00_0500, 8'h00, 0);
        rd(OP_READ, 24'h00_0FFE, 8'h81, 8'h3C);
        lk(1'b0, 1'b0);
        $display("test locks done");
        rd(OP_IDENT_READ_A, 24'h00_0001, ID_PART, ID_PART);
        rd(OP_IDENT_READ_B, 24'h00_0000, ID_MAKER, ID_MAKER);
        host.sel();
        host.bits(8'h12, 8, x);
        host.bits(OP_STATUS_READ, 8, x);
        host.bits(8'h00, 8, x);
        chk({7'h0, so_oe_n}, 8'h01);
        host.desel();
        $display("test ident and unknown done");
        one(OP_BUSY_OUT_EN);
        wr(OP_AUTO_INC_PROG, 24'h00_0FF2, 8'h12, 8);
        chk({7'h0, auto_increment_program}, 8'h00);
        aai2(24'h00_0FF2, 8'h12, 8'h34);
        idle();
        chk({7'h0, auto_increment_program}, 8'h01);
        host.sel();
        host.bits(OP_AUTO_INC_PROG, 8, x);
        host.bits(8'h56, 8, x);
        host.bits(8'h78, 8, x);
        host.desel();
        pin(8'h00);
        idle();
        pin(8'h01);
        one(OP_WRITE_DISABLE);
        stat(OP_STATUS_READ, 8'h00);
        one(OP_BUSY_OUT_DIS);
        aai2(24'h00_0FF6, 8'h9A, 8'hBC);
        pin(8'h02);
        idle();
        one(OP_WRITE_DISABLE);
        rd(OP_READ, 24'h00_0FF2, 8'h12, 8'h34);
        rd(OP_READ, 24'h00_0FF4, 8'h56, 8'h78);
        $display("test auto increment done");
        test_done();
    end
endmodule : sfc_core_tb_top
